// File: core/dolc_pkg.sv
// Purpose: Constants and types for the demodulator offset loop block
// Assumes: One 100 MHz clock, registers reached through a byte-wide register port
// Notes:   Gains are kept in half-unit steps so that K/2 is an integer
//
// Contract
// - Gate bit freezes both loops until carrier sense
// - Frequency pre-sync gain is K times (field+1)
// - Frequency post-sync gain is pre gain or K/2
// - Frequency saturation off, BW/8, BW/4, BW/2
// - Clock recovery pre-sync integral gain Ki times (field+1)
// - Clock recovery pre-sync proportional gain Kp times (field+1)
// - Integral post-sync gain is pre gain or Ki/2
// - Proportional post-sync gain is pre gain or Kp
// - Rate saturation off, 3.125, 6.25, 12.5 percent
package dolc_pkg;

   // ----------------------------------------------------------------
   // Register port map
   // ----------------------------------------------------------------
   localparam logic [7:0] DOLC_FREQ_CFG_IDX = 8'h19;
   localparam logic [7:0] DOLC_BS_CFG_IDX = 8'h1a;
   localparam logic [7:0] DOLC_FREQ_CFG_RST = 8'h36;
   localparam logic [7:0] DOLC_BS_CFG_RST = 8'h6c;
   localparam logic [7:0] DOLC_FREQ_CFG_MASK = 8'h3f;

   // ----------------------------------------------------------------
   // Datapath widths and scaling
   // ----------------------------------------------------------------
   localparam int DOLC_ERR_W = 8;
   localparam int DOLC_ACC_W = 12;
   localparam int DOLC_GAIN_W = 4;
   // Accumulator full scale stands for BW/2 or for 12.5 percent
   localparam logic [DOLC_ACC_W-2:0] DOLC_FULL_SCALE = 11'h400;
   // Gain codes in half units: K/2 is 1, K is 2, 4K is 8
   localparam logic [DOLC_GAIN_W-1:0] DOLC_GAIN_HALF = 4'h1;
   localparam logic [DOLC_GAIN_W-1:0] DOLC_GAIN_UNIT = 4'h2;
   localparam logic [1:0] DOLC_LIMIT_OFF = 2'h0;

   // ----------------------------------------------------------------
   // Register layouts
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] reserved;
      logic loops_gate_on_carrier;
      logic [1:0] freq_gain_pre_sync;
      logic freq_gain_post_sync;
      logic [1:0] freq_offset_saturation;
   } dolc_freq_cfg_s;

   typedef struct packed {
      logic [1:0] clkrec_integral_pre_sync;
      logic [1:0] clkrec_proportional_pre_sync;
      logic clkrec_integral_post_sync;
      logic clkrec_proportional_post_sync;
      logic [1:0] rate_offset_saturation;
   } dolc_bs_cfg_s;

   // Register port request
   typedef struct packed {
      logic wr;
      logic [7:0] idx;
      logic [7:0] wdata;
   } dolc_reg_req_s;

endpackage : dolc_pkg

// File: core/dolc_sat_acc.sv
// Purpose: Saturating signed accumulator used by both tracking loops
// Assumes: Limit never exceeds the accumulator range
// Notes:   A zero limit pins the accumulator at zero
`timescale 1ns/1ps
`default_nettype none
module dolc_sat_acc
   import dolc_pkg::*;
(
   input wire logic ref_clk_i, // System clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic en_i, // Accumulate this cycle
   input wire logic clr_i, // Restart at zero
   input wire logic signed [DOLC_ACC_W-1:0] step_i, // Increment
   input wire logic [DOLC_ACC_W-2:0] limit_i, // Symmetric bound
   output logic signed [DOLC_ACC_W-1:0] acc_o // Accumulator value
);

   logic signed [DOLC_ACC_W-1:0] acc_q;
   logic signed [DOLC_ACC_W-1:0] acc_d;
   logic signed [DOLC_ACC_W:0] sum;
   logic signed [DOLC_ACC_W:0] lim_pos;
   logic signed [DOLC_ACC_W:0] lim_neg;

   // ----------------------------------------------------------------
   // Next value with clamp
   // ----------------------------------------------------------------
   always_comb begin
      sum = (DOLC_ACC_W+1)'(acc_q);
      if (en_i) begin
         sum = sum + (DOLC_ACC_W+1)'(step_i);
      end
      lim_pos = $signed({2'b00, limit_i});
      lim_neg = -lim_pos;
      // Clamp on the wide sum every cycle: a wrap never escapes the bound,
      // and a lowered limit pulls a held value in without a new sample
      if (clr_i) begin
         acc_d = '0;
      end else if (sum > lim_pos) begin
         acc_d = lim_pos[DOLC_ACC_W-1:0];
      end else if (sum < lim_neg) begin
         acc_d = lim_neg[DOLC_ACC_W-1:0];
      end else begin
         acc_d = sum[DOLC_ACC_W-1:0];
      end
   end

   // Register stage
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_q <= '0;
      end else begin
         acc_q <= acc_d;
      end
   end

   assign acc_o = acc_q;

endmodule : dolc_sat_acc
`default_nettype wire

// File: core/dolc_top.sv
// Purpose: Frequency offset and clock recovery tracking loops with config registers
// Assumes: Error samples arrive with a one-cycle valid strobe, inputs synchronous
// Notes:   Output offsets are in accumulator units, full scale BW/2 or 12.5 percent
//          Post-sync gains switch in on the very cycle of detection
`timescale 1ns/1ps
`default_nettype none
module dolc_top
   import dolc_pkg::*;
(
   input wire logic ref_clk_i, // 100 MHz clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic reg_wr_i, // Register write strobe
   input wire logic reg_rd_i, // Register read strobe
   input wire logic [7:0] reg_idx_i, // Register index
   input wire logic [7:0] reg_wdata_i, // Write data
   output logic [7:0] reg_rdata_o, // Read data, one cycle after strobe
   input wire logic rx_start_i, // Start of reception pulse
   input wire logic sync_det_i, // Sync word detected pulse
   input wire logic carrier_sense_i, // Carrier sense level
   input wire logic err_valid_i, // Error samples valid
   input wire logic signed [DOLC_ERR_W-1:0] freq_err_i, // Frequency discriminator error
   input wire logic signed [DOLC_ERR_W-1:0] timing_err_i, // Timing detector error
   output logic signed [DOLC_ACC_W-1:0] freq_offset_o, // Compensated frequency offset
   output logic signed [DOLC_ACC_W-1:0] rate_offset_o, // Data rate correction
   output logic loops_frozen_o, // Loops currently held
   output logic post_sync_o // Post-sync gains in use
);

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   dolc_freq_cfg_s freq_cfg_q;
   dolc_freq_cfg_s freq_cfg_d;
   dolc_bs_cfg_s bs_cfg_q;
   dolc_bs_cfg_s bs_cfg_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   dolc_reg_req_s req;
   logic hit_freq;
   logic hit_bs;

   assign req = '{wr: reg_wr_i, idx: reg_idx_i, wdata: reg_wdata_i};

   // Index match per register; a write elsewhere touches nothing
   assign hit_freq = req.wr && (req.idx == DOLC_FREQ_CFG_IDX);
   assign hit_bs = req.wr && (req.idx == DOLC_BS_CFG_IDX);

   // Write decode; reserved bits of the frequency register stay zero
   always_comb begin
      freq_cfg_d = freq_cfg_q;
      bs_cfg_d = bs_cfg_q;
      if (hit_freq) begin
         freq_cfg_d = dolc_freq_cfg_s'(req.wdata & DOLC_FREQ_CFG_MASK);
      end
      if (hit_bs) begin
         bs_cfg_d = dolc_bs_cfg_s'(req.wdata);
      end
   end

   // ----------------------------------------------------------------
   // Register read path
   // ----------------------------------------------------------------
   // Read mux; unknown index reads zero
   always_comb begin
      rdata_d = rdata_q;
      if (reg_rd_i) begin
         unique case (reg_idx_i)
            DOLC_FREQ_CFG_IDX: rdata_d = 8'(freq_cfg_q);
            DOLC_BS_CFG_IDX: rdata_d = 8'(bs_cfg_q);
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // Reset values put gate, gains and limits at their defaults
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         freq_cfg_q <= dolc_freq_cfg_s'(DOLC_FREQ_CFG_RST);
         bs_cfg_q <= dolc_bs_cfg_s'(DOLC_BS_CFG_RST);
         rdata_q <= 8'h00;
      end else begin
         freq_cfg_q <= freq_cfg_d;
         bs_cfg_q <= bs_cfg_d;
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // Reception phase tracking
   // ----------------------------------------------------------------
   logic sync_q;
   logic sync_d;
   logic cs_seen_q;
   logic cs_seen_d;
   logic post_now;
   logic frozen_now;
   logic sync_live;
   logic cs_live;

   // Start of reception clears both; a same-cycle event still wins
   always_comb begin
      sync_d = sync_q;
      cs_seen_d = cs_seen_q;
      if (rx_start_i) begin
         sync_d = 1'b0;
         cs_seen_d = 1'b0;
      end
      if (sync_det_i) begin
         sync_d = 1'b1;
      end
      if (carrier_sense_i) begin
         cs_seen_d = 1'b1;
      end
   end

   // Flag registers
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_q <= 1'b0;
         cs_seen_q <= 1'b0;
      end else begin
         sync_q <= sync_d;
         cs_seen_q <= cs_seen_d;
      end
   end

   // Flags as seen this cycle; a start drops the old reception's history
   assign sync_live = (sync_q & ~rx_start_i) | sync_det_i;
   assign cs_live = (cs_seen_q & ~rx_start_i) | carrier_sense_i;

   // Post gains apply from the very cycle of detection
   assign post_now = sync_live;
   // Held until carrier sense rises within this reception
   assign frozen_now = freq_cfg_q.loops_gate_on_carrier & ~cs_live;

   // ----------------------------------------------------------------
   // Gain selection, half-unit codes
   // ----------------------------------------------------------------
   logic [DOLC_GAIN_W-1:0] freq_gain;
   logic [DOLC_GAIN_W-1:0] ki_gain;
   logic [DOLC_GAIN_W-1:0] kp_gain;
   logic [DOLC_GAIN_W-1:0] freq_pre;
   logic [DOLC_GAIN_W-1:0] ki_pre;
   logic [DOLC_GAIN_W-1:0] kp_pre;

   // Half-unit code of (field+1) times the base gain
   function automatic logic [DOLC_GAIN_W-1:0] dolc_pre_gain(input logic [1:0] fld);
      logic [DOLC_GAIN_W-1:0] mult;
      mult = DOLC_GAIN_W'(fld) + 4'h1;
      return DOLC_GAIN_W'(mult * DOLC_GAIN_UNIT);
   endfunction : dolc_pre_gain

   // Post codes override the pre codes once sync is live
   always_comb begin
      freq_pre = dolc_pre_gain(freq_cfg_q.freq_gain_pre_sync);
      ki_pre = dolc_pre_gain(bs_cfg_q.clkrec_integral_pre_sync);
      kp_pre = dolc_pre_gain(bs_cfg_q.clkrec_proportional_pre_sync);
      freq_gain = freq_pre;
      ki_gain = ki_pre;
      kp_gain = kp_pre;
      if (post_now) begin
         if (freq_cfg_q.freq_gain_post_sync) begin
            freq_gain = DOLC_GAIN_HALF;
         end
         if (bs_cfg_q.clkrec_integral_post_sync) begin
            ki_gain = DOLC_GAIN_HALF;
         end
         if (bs_cfg_q.clkrec_proportional_post_sync) begin
            kp_gain = DOLC_GAIN_UNIT;
         end
      end
   end

   // ----------------------------------------------------------------
   // Saturation limits
   // ----------------------------------------------------------------
   logic [DOLC_ACC_W-2:0] freq_limit;
   logic [DOLC_ACC_W-2:0] rate_limit;

   // Setting 3 is full scale, each step down halves it, 0 turns off
   function automatic logic [DOLC_ACC_W-2:0] dolc_limit(input logic [1:0] fld);
      logic [DOLC_ACC_W-2:0] lim;
      unique case (fld)
         2'h0: lim = '0;
         2'h1: lim = DOLC_FULL_SCALE >> 2;
         2'h2: lim = DOLC_FULL_SCALE >> 1;
         2'h3: lim = DOLC_FULL_SCALE;
      endcase
      return lim;
   endfunction : dolc_limit

   // The host keeps the frequency limit at zero for ASK/OOK
   assign freq_limit = dolc_limit(freq_cfg_q.freq_offset_saturation);
   assign rate_limit = dolc_limit(bs_cfg_q.rate_offset_saturation);

   // ----------------------------------------------------------------
   // Loop steps
   // ----------------------------------------------------------------
   logic signed [DOLC_ACC_W-1:0] freq_step;
   logic signed [DOLC_ACC_W-1:0] ki_step;
   logic signed [DOLC_ACC_W-1:0] kp_term;
   logic loop_en;

   logic signed [DOLC_ACC_W-1:0] freq_err_x;
   logic signed [DOLC_ACC_W-1:0] timing_err_x;
   logic signed [DOLC_ACC_W-1:0] freq_gain_x;
   logic signed [DOLC_ACC_W-1:0] ki_gain_x;
   logic signed [DOLC_ACC_W-1:0] kp_gain_x;

   // Widen before multiplying: a full-scale error at 4K needs eleven bits
   always_comb begin
      freq_err_x = DOLC_ACC_W'(freq_err_i);
      timing_err_x = DOLC_ACC_W'(timing_err_i);
      freq_gain_x = $signed({{(DOLC_ACC_W-DOLC_GAIN_W){1'b0}}, freq_gain});
      ki_gain_x = $signed({{(DOLC_ACC_W-DOLC_GAIN_W){1'b0}}, ki_gain});
      kp_gain_x = $signed({{(DOLC_ACC_W-DOLC_GAIN_W){1'b0}}, kp_gain});
   end

   // Error times half-unit gain; the product fits the accumulator width
   always_comb begin
      freq_step = freq_err_x * freq_gain_x;
      ki_step = timing_err_x * ki_gain_x;
      kp_term = timing_err_x * kp_gain_x;
   end

   // A frozen loop keeps its state, it is not cleared
   assign loop_en = err_valid_i & ~frozen_now;

   logic signed [DOLC_ACC_W-1:0] freq_acc;
   logic signed [DOLC_ACC_W-1:0] integ_acc;

   dolc_sat_acc u_freq_acc (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .en_i(loop_en),
      .clr_i(rx_start_i),
      .step_i(freq_step),
      .limit_i(freq_limit),
      .acc_o(freq_acc)
   );

   dolc_sat_acc u_integ_acc (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .en_i(loop_en),
      .clr_i(rx_start_i),
      .step_i(ki_step),
      .limit_i(rate_limit),
      .acc_o(integ_acc)
   );

   // ----------------------------------------------------------------
   // Output stage
   // ----------------------------------------------------------------
   logic signed [DOLC_ACC_W-1:0] rate_q;
   logic signed [DOLC_ACC_W-1:0] rate_d;
   logic signed [DOLC_ACC_W-1:0] freq_q;
   logic signed [DOLC_ACC_W-1:0] freq_d;
   logic frozen_q;
   logic post_q;
   logic signed [DOLC_ACC_W:0] rate_sum;
   logic signed [DOLC_ACC_W:0] rlim_pos;
   logic signed [DOLC_ACC_W:0] rlim_neg;

   // Proportional path only acts on a live sample; whole sum clamped
   always_comb begin
      rlim_pos = $signed({2'b00, rate_limit});
      rlim_neg = -rlim_pos;
      rate_sum = (DOLC_ACC_W+1)'(integ_acc);
      if (loop_en) begin
         rate_sum = rate_sum + (DOLC_ACC_W+1)'(kp_term);
      end
      if (rate_sum > rlim_pos) begin
         rate_d = rlim_pos[DOLC_ACC_W-1:0];
      end else if (rate_sum < rlim_neg) begin
         rate_d = rlim_neg[DOLC_ACC_W-1:0];
      end else begin
         rate_d = rate_sum[DOLC_ACC_W-1:0];
      end
      freq_d = freq_acc;
   end

   // Every port leaves a flop, so status lags the loop by one cycle
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rate_q <= '0;
         freq_q <= '0;
         frozen_q <= 1'b0;
         post_q <= 1'b0;
      end else begin
         rate_q <= rate_d;
         freq_q <= freq_d;
         frozen_q <= frozen_now;
         post_q <= post_now;
      end
   end

   // Ports come straight from the output flops
   assign reg_rdata_o = rdata_q;
   assign freq_offset_o = freq_q;
   assign rate_offset_o = rate_q;
   assign loops_frozen_o = frozen_q;
   assign post_sync_o = post_q;

endmodule : dolc_top
`default_nettype wire

// File: verification/dolc_host_model.sv
// Purpose: Host side register access model for the offset loop block
// Assumes: Strobes go out just after a rising edge
// Notes:   Released index and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module dolc_host_model
   import dolc_pkg::*;
(
   input wire logic ref_clk_i, // Clock
   input wire logic [7:0] reg_rdata_i, // Read data from block
   output logic reg_wr_o, // Write strobe
   output logic reg_rd_o, // Read strobe
   output logic [7:0] reg_idx_o, // Index
   output logic [7:0] reg_wdata_o // Write data
);
   // Idle bus at time zero
   initial begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_idx_o = 8'h00;
      reg_wdata_o = 8'h00;
   end

   // One access held for exactly one taking edge
   task automatic acc(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge ref_clk_i);
      #1;
      reg_wr_o = wr;
      reg_rd_o = !wr;
      reg_idx_o = idx;
      reg_wdata_o = wd;
      @(posedge ref_clk_i);
      #1;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_idx_o = ~idx;
      reg_wdata_o = ~wd;
   endtask : acc

   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      acc(1'b1, idx, wd);
   endtask : wr

   // Read data is registered at the taking edge
   task automatic rd(input logic [7:0] idx, output logic [7:0] d);
      acc(1'b0, idx, 8'h00);
      d = reg_rdata_i;
   endtask : rd

   // Amplitude keyed formats: offset compensation unsupported, limit zero
   task automatic ask_mode(input logic [7:0] cfg);
      wr(DOLC_FREQ_CFG_IDX, cfg & 8'hfc);
   endtask : ask_mode
endmodule : dolc_host_model
`default_nettype wire

// File: verification/dolc_top_asserts.sv
// Purpose: Port level checks for the offset loop block
// Assumes: Shadow config bytes follow the write port
// Notes:   Gain values are checked by the bench, not here
`timescale 1ns/1ps
`default_nettype none
module dolc_asserts
   import dolc_pkg::*;
(
   input wire logic ref_clk_i, // Clock
   input wire logic rst_n_i, // Reset, active low
   input wire logic reg_wr_i, // Write strobe
   input wire logic reg_rd_i, // Read strobe
   input wire logic [7:0] reg_idx_i, // Index
   input wire logic [7:0] reg_wdata_i, // Write data
   input wire logic [7:0] reg_rdata_o, // Read data
   input wire logic rx_start_i, // Reception start
   input wire logic sync_det_i, // Sync pulse
   input wire logic carrier_sense_i, // Carrier sense
   input wire logic signed [DOLC_ACC_W-1:0] freq_offset_o, // Frequency offset
   input wire logic signed [DOLC_ACC_W-1:0] rate_offset_o, // Rate offset
   input wire logic loops_frozen_o, // Loops held
   input wire logic post_sync_o // Post gains
);
   // Shadow config bytes, so reads and limits can be predicted
   logic [7:0] fcfg_q, fcfg_d, bcfg_q, bcfg_d;
   always_comb begin
      fcfg_d = fcfg_q;
      bcfg_d = bcfg_q;
      if (reg_wr_i && reg_idx_i == DOLC_FREQ_CFG_IDX) fcfg_d = reg_wdata_i & DOLC_FREQ_CFG_MASK;
      if (reg_wr_i && reg_idx_i == DOLC_BS_CFG_IDX) bcfg_d = reg_wdata_i;
   end
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fcfg_q <= DOLC_FREQ_CFG_RST;
         bcfg_q <= DOLC_BS_CFG_RST;
      end else begin
         fcfg_q <= fcfg_d;
         bcfg_q <= bcfg_d;
      end
   end

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   rd_miss_a: assert property (reg_rd_i && reg_idx_i != DOLC_FREQ_CFG_IDX
      && reg_idx_i != DOLC_BS_CFG_IDX |=> reg_rdata_o == 8'h00) else $error("unmapped read");
   rd_freq_a: assert property (reg_rd_i && reg_idx_i == DOLC_FREQ_CFG_IDX
      |=> reg_rdata_o == $past(fcfg_q)) else $error("freq cfg read");
   freq_zero_a: assert property ((fcfg_q[1:0] == 2'h0) [*3]
      |-> freq_offset_o == 12'sh000) else $error("freq not off");
   rate_zero_a: assert property ((bcfg_q[1:0] == 2'h0) [*3]
      |-> rate_offset_o == 12'sh000) else $error("rate not off");
   cs_run_a: assert property (carrier_sense_i |=> !loops_frozen_o)
      else $error("frozen under carrier");
   // Gate held and no carrier: a dropped sample must not move the output
   frozen_hold_a: assert property (loops_frozen_o && !carrier_sense_i && !rx_start_i
      && !reg_wr_i && !$past(reg_wr_i) |=> ##1 $stable(freq_offset_o)) else $error("moved");
   post_set_a: assert property (sync_det_i && !rx_start_i |=> post_sync_o)
      else $error("post gains late");
   rx_clear_a: assert property (rx_start_i && !sync_det_i |=> !post_sync_o)
      else $error("post not cleared");

   cover property (loops_frozen_o ##1 !loops_frozen_o);
   cover property (sync_det_i && !rx_start_i);
   cover property (fcfg_q[1:0] == 2'h0 && freq_offset_o == 12'sh000);
endmodule : dolc_asserts

bind dolc_top dolc_asserts i_chk (.ref_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_idx_i,
   .reg_wdata_i, .reg_rdata_o, .rx_start_i, .sync_det_i, .carrier_sense_i, .freq_offset_o,
   .rate_offset_o, .loops_frozen_o, .post_sync_o);
`default_nettype wire

// File: verification/dolc_top_tb.sv
// Purpose: Self-checking bench for the offset loop block
// Assumes: Host model drives the register port
// Notes:   Each loop test starts from a reception start
`timescale 1ns/1ps
`default_nettype none
module dolc_top_tb
   import dolc_pkg::*;
   ;
   logic ref_clk_i, rst_n_i, reg_wr_i, reg_rd_i, rx_start_i, sync_det_i, carrier_sense_i;
   logic err_valid_i, loops_frozen_o, post_sync_o;
   logic [7:0] reg_idx_i, reg_wdata_i, reg_rdata_o, rd_v;
   logic signed [DOLC_ERR_W-1:0] freq_err_i, timing_err_i;
   logic signed [DOLC_ACC_W-1:0] freq_offset_o, rate_offset_o;
   int n_fail = 0;
   int n_checks = 0;
   int lim[4] = '{0, 256, 512, 1024};
   int sg;
   int mx;

   dolc_top i_dut (.ref_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_idx_i, .reg_wdata_i,
      .reg_rdata_o, .rx_start_i, .sync_det_i, .carrier_sense_i, .err_valid_i, .freq_err_i,
      .timing_err_i, .freq_offset_o, .rate_offset_o, .loops_frozen_o, .post_sync_o);
   dolc_host_model i_host (.ref_clk_i, .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i),
      .reg_rd_o(reg_rd_i), .reg_idx_o(reg_idx_i), .reg_wdata_o(reg_wdata_i));

   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test

   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
      i_host.rd(idx, rd_v);
      check({4'h0, rd_v}, {4'h0, exp});
   endtask : rdchk

   task automatic rx;
      @(posedge ref_clk_i);
      #1;
      rx_start_i = 1'b1;
      @(posedge ref_clk_i);
      #1;
      rx_start_i = 1'b0;
   endtask : rx

   // One error sample; proportional term shows one cycle before the integral
   task automatic sample(input int fe, input int te, input logic sy, input int xf,
      input int xp, input int xi);
      @(posedge ref_clk_i);
      #1;
      err_valid_i = 1'b1;
      sync_det_i = sy;
      freq_err_i = 8'(fe);
      timing_err_i = 8'(te);
      @(posedge ref_clk_i);
      #1;
      err_valid_i = 1'b0;
      sync_det_i = 1'b0;
      check(rate_offset_o, 12'(xp));
      @(posedge ref_clk_i);
      #1;
      check(freq_offset_o, 12'(xf));
      check(rate_offset_o, 12'(xi));
   endtask : sample

   initial begin
      #50us;
      n_fail++;
      finish_test;
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_n_i = 1'b0;
      rx_start_i = 1'b0;
      sync_det_i = 1'b0;
      carrier_sense_i = 1'b0;
      err_valid_i = 1'b0;
      freq_err_i = 8'sh00;
      timing_err_i = 8'sh00;
      repeat (20) @(posedge ref_clk_i);
      #1;
      rst_n_i = 1'b1;
      rdchk(DOLC_FREQ_CFG_IDX, 8'h36);
      rdchk(DOLC_BS_CFG_IDX, 8'h6c);
      rdchk(8'h42, 8'h00);
      i_host.wr(DOLC_FREQ_CFG_IDX, 8'hff);
      rdchk(DOLC_FREQ_CFG_IDX, 8'h3f);
      // Gate on without carrier drops the sample, carrier releases the loops
      i_host.wr(DOLC_FREQ_CFG_IDX, 8'h36);
      rx;
      sample(10, 1, 1'b0, 0, 0, 0);
      check({11'h0, loops_frozen_o}, 12'h001);
      carrier_sense_i = 1'b1;
      sample(10, 1, 1'b0, 60, 0, 0);
      carrier_sense_i = 1'b0;
      sample(10, 1, 1'b0, 120, 0, 0);
      check({11'h0, loops_frozen_o}, 12'h000);
      for (int n = 0; n < 4; n++) begin
         i_host.wr(DOLC_FREQ_CFG_IDX, {3'h0, 2'(n), 3'h3});
         i_host.wr(DOLC_BS_CFG_IDX, {2'(n), 2'(3 - n), 4'h3});
         rx;
         sample(10, 5, 1'b0, 20 * (n + 1), 10 * (4 - n), 10 * (n + 1));
      end
      // Sync in the same cycle as the sample already uses post gains
      for (int p = 0; p < 2; p++) begin
         i_host.wr(DOLC_FREQ_CFG_IDX, {5'h01, 1'(p), 2'h3});
         i_host.wr(DOLC_BS_CFG_IDX, {2'h1, 2'h2, 1'(p), 1'(p), 2'h3});
         rx;
         sample(10, 5, 1'b1, p ? 10 : 40, p ? 10 : 30, p ? 5 : 20);
         check({11'h0, post_sync_o}, 12'h001);
         sample(10, 5, 1'b0, p ? 20 : 80, p ? 15 : 50, p ? 10 : 40);
      end
      // Odd settings drive negative errors so both clamp ends are reached;
      // a full-scale error at 4K moves 1016, short of the widest limit
      for (int l = 0; l < 4; l++) begin
         if (l == 0) i_host.ask_mode(8'h18);
         else i_host.wr(DOLC_FREQ_CFG_IDX, {6'h06, 2'(l)});
         i_host.wr(DOLC_BS_CFG_IDX, {6'h3c, 2'(l)});
         rx;
         sg = (l % 2 == 1) ? -1 : 1;
         mx = (lim[l] > 1016) ? 1016 : lim[l];
         sample(sg * 127, sg * 127, 1'b0, sg * mx, sg * mx, sg * mx);
         sample(sg * 127, sg * 127, 1'b0, sg * lim[l], sg * lim[l], sg * lim[l]);
      end
      finish_test;
   end
endmodule : dolc_top_tb
`default_nettype wire
